// >>> shared/mahp_pkg.sv
// Shared constants and types of the four-axis host port.
// Assumes both port ends and the testbench import it whole.
`default_nettype none
package mahp_pkg;

	// ----------------------------------------------------------------
	// Local byte offsets, repeated for every axis
	// ----------------------------------------------------------------
	localparam logic [2:0] OFS_CMD_CODE    = 3'h0;
	localparam logic [2:0] OFS_AXIS_SEL    = 3'h1;
	localparam logic [2:0] OFS_GP_PORT     = 3'h2;
	localparam logic [2:0] OFS_SUB_STATE   = 3'h3;
	localparam logic [2:0] OFS_BUF_BYTE0   = 3'h4;
	localparam logic [7:0] OFS_DIRECT_BASE = 8'h08;
	localparam logic [5:0] DIRECT_BIAS     = 6'h02;

	// ----------------------------------------------------------------
	// Command word layout
	// ----------------------------------------------------------------
	localparam logic [1:0] CMD_CLASS_REG_WR = 2'h2;
	localparam logic [1:0] CMD_CLASS_REG_RD = 2'h3;
	localparam logic [3:0] SEL_NONE         = 4'h0;

	// ----------------------------------------------------------------
	// Wait periods in device clock cycles
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_WAIT_CYCLES    = 3'h4;
	localparam logic [2:0] BUF_WAIT_CYCLES    = 3'h2;
	localparam logic [2:0] DIRECT_WAIT_CYCLES = 3'h3;
	localparam logic [2:0] HOST_STROBE_CYCLES = 3'h3;
	localparam logic [2:0] HOST_GAP_CYCLES    = 3'h4;
	localparam logic [2:0] CNT_ZERO           = 3'h0;

	typedef logic [3:0] mahp_axes_t;

	typedef enum logic [1:0] {
		MAHP_H_IDLE   = 2'b00,
		MAHP_H_SETUP  = 2'b01,
		MAHP_H_STROBE = 2'b10,
		MAHP_H_GAP    = 2'b11
	} mahp_host_state_t;

endpackage
`default_nettype wire

// >>> shared/mahp_bus_if.sv
// Parallel host bus between the host end and the device end.
// Assumes the testbench instantiates it and joins both ends to it.
`timescale 1ns/1ps
`default_nettype none
interface mahp_bus_if;
	logic        cs_n;
	logic        wr_n;
	logic        rd_n;
	logic [9:0]  addr;
	logic [15:0] host_d;
	logic        host_d_oe;
	logic [15:0] dev_d;
	logic        dev_d_oe;
	logic [15:0] data;
	logic        wrq_n;
	logic        ifb_n;
	logic        mode_16;
	logic        full_addr;

	// A pull-up stands in for an undriven data bus.
	assign data = dev_d_oe ? dev_d : (host_d_oe ? host_d : 16'hFFFF);

	modport device (input cs_n, wr_n, rd_n, addr, data, mode_16, full_addr,
		output dev_d, dev_d_oe, wrq_n, ifb_n);
	modport host (output cs_n, wr_n, rd_n, addr, host_d, host_d_oe, mode_16, full_addr,
		input data, wrq_n, ifb_n);
endinterface
`default_nettype wire

// >>> core/mahp_xfer_buffer.sv
// One axis's 32-bit transfer buffer with byte-lane writes and a bulk load.
// Assumes a write and a load never fall in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module mahp_xfer_buffer
	import mahp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  wr_be,
	input  wire logic [31:0] wr_data,
	input  wire logic        load,
	input  wire logic [31:0] load_data,
	output logic      [31:0] data
);
	logic [31:0] next_data;

	// Contents stay until overwritten, so stale bytes survive a partial write.
	always_comb begin
		next_data = data;
		if (load) begin
			next_data = load_data;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_be[i]) begin
					next_data[8*i +: 8] = wr_data[8*i +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data <= 32'h0000_0000;
		end else begin
			data <= next_data;
		end
	end
endmodule
`default_nettype wire

// >>> core/mahp_device.sv
// Device end of the four-axis host port: decode, command, buffers, pacing.
// Assumes synchronous bus inputs and a core that takes register strobes.
//
// How it works
// [RULE1] Upper two address bits pick the axis.
// [RULE2] Command code low byte, axis selects bits 8-11.
// [RULE3] Several selects apply one command to each.
// [RULE4] No selects means the addressed axis only.
// [RULE5] Byte mode: select byte first, code triggers.
// [RULE6] Word modes write select and code together.
// [RULE7] Busy held low through each wait period.
// [RULE8] Wait request low while selected and busy.
// [RULE9] Host without wait waits four cycles.
// [RULE10] Direct writes only with full addressing.
// [RULE11] Direct write commits at highest address.
// [RULE12] Long write strobe avoids wait fault.
// [RULE13] Chip select gap finishes direct writes.
// [RULE14] Per-axis 32-bit buffer, parts any order.
// [RULE15] Buffer keeps contents until overwritten.
// [RULE16] Host waits two cycles per buffer write.
// [RULE17] Register write moves whole buffer at once.
// [RULE18] Multi-axis write loads each from own buffer.
// [RULE19] Direct reads only with full addressing; the code returns zero for them.
// [RULE20] Reads and writes use separate sources.
`timescale 1ns/1ps
`default_nettype none
module mahp_device
	import mahp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              nrst,
	mahp_bus_if.device             bus,
	output logic                   cmd_valid,
	output logic [7:0]             cmd_code,
	output mahp_axes_t             cmd_axes,
	output logic                   reg_wr,
	output logic                   reg_rd,
	output logic [5:0]             reg_index,
	output mahp_axes_t             reg_axes,
	output logic [3:0][31:0]       reg_wdata,
	input  wire logic [3:0][31:0]  reg_rdata,
	input  wire logic [3:0][15:0]  main_state,
	input  wire logic [3:0][7:0]   sub_state,
	input  wire logic [3:0][7:0]   port_in,
	output logic [3:0][7:0]        port_out
);
	// ----------------------------------------------------------------
	// Write cycle capture
	// ----------------------------------------------------------------
	logic        wr_act;
	logic        wr_prev;
	logic [9:0]  wr_addr;
	logic [15:0] wr_data;
	logic        wr_end;

	assign wr_act = !bus.cs_n && !bus.wr_n;
	// Acting on the strobe's rising edge uses the data the host held last.
	assign wr_end = wr_prev && !wr_act;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_prev <= 1'b0;
			wr_addr <= 10'h000;
			wr_data <= 16'h0000;
		end else begin
			wr_prev <= wr_act;
			if (wr_act) begin
				wr_addr <= bus.addr;
				wr_data <= bus.data;
			end
		end
	end

	// ----------------------------------------------------------------
	// Decode of the finished write
	// ----------------------------------------------------------------
	logic [1:0]  axis;
	logic [2:0]  ofs;
	logic        direct;
	logic        cmd_hit;
	logic [3:0]  sel_latch;
	logic [3:0]  sel_src;
	mahp_axes_t  axes;
	logic [3:0]  buf_be;
	logic [31:0] buf_wdata;
	logic        dir_first;
	logic        dir_last;

	always_comb begin
		axis      = wr_addr[9:8]; // RULE1
		ofs       = bus.mode_16 ? {wr_addr[2:1], 1'b0} : wr_addr[2:0];
		direct    = bus.full_addr && (wr_addr[7:0] >= OFS_DIRECT_BASE); // RULE10
		cmd_hit   = wr_end && !direct && (ofs == OFS_CMD_CODE); // RULE5 RULE6
		sel_src   = bus.mode_16 ? wr_data[11:8] : sel_latch; // RULE2
		axes      = (sel_src == SEL_NONE) ? mahp_axes_t'(4'h1 << axis) : sel_src; // RULE3 RULE4
		buf_be    = bus.mode_16 ? (ofs[1] ? 4'hC : 4'h3) : 4'(4'h1 << ofs[1:0]); // RULE14
		buf_wdata = bus.mode_16 ? {2{wr_data}} : {4{wr_data[7:0]}};
		dir_first = bus.mode_16 ? !wr_addr[1] : (wr_addr[1:0] == 2'h0);
		dir_last  = bus.mode_16 ? wr_addr[1] : (wr_addr[1:0] == 2'h3);
	end

	// ----------------------------------------------------------------
	// Command, port, direct staging and pacing state
	// ----------------------------------------------------------------
	logic [3:0]       next_sel_latch;
	logic [3:0][7:0]  next_port_out;
	logic [31:0]      stage;
	logic [31:0]      next_stage;
	logic [2:0]       busy_cnt;
	logic [2:0]       next_busy_cnt;
	mahp_axes_t       rd_load;
	mahp_axes_t       next_rd_load;
	logic             next_cmd_valid;
	logic [7:0]       next_cmd_code;
	mahp_axes_t       next_cmd_axes;
	logic             next_reg_wr;
	logic             next_reg_rd;
	logic [5:0]       next_reg_index;
	mahp_axes_t       next_reg_axes;
	logic [3:0][31:0] next_reg_wdata;
	logic [3:0][31:0] buf_q;

	always_comb begin
		next_sel_latch = sel_latch;
		next_port_out  = port_out;
		next_stage     = stage;
		next_busy_cnt  = (busy_cnt == CNT_ZERO) ? CNT_ZERO : busy_cnt - 3'h1;
		next_rd_load   = '0;
		next_cmd_valid = 1'b0;
		next_cmd_code  = cmd_code;
		next_cmd_axes  = cmd_axes;
		next_reg_wr    = 1'b0;
		next_reg_rd    = 1'b0;
		next_reg_index = reg_index;
		next_reg_axes  = reg_axes;
		next_reg_wdata = reg_wdata;
		if (wr_end && !direct) begin
			if (!bus.mode_16 && ofs == OFS_AXIS_SEL) begin
				next_sel_latch = wr_data[3:0]; // RULE5
			end
			if (ofs == OFS_GP_PORT) begin
				next_port_out[axis] = wr_data[7:0];
			end
			if (ofs[2]) begin
				next_busy_cnt = BUF_WAIT_CYCLES; // RULE16
			end
		end
		if (cmd_hit) begin
			next_busy_cnt = CMD_WAIT_CYCLES; // RULE7 RULE9 RULE17
			next_cmd_code = wr_data[7:0];
			next_cmd_axes = axes;
			case (wr_data[7:6])
				CMD_CLASS_REG_WR: begin
					// Each axis takes its own buffer in the same cycle.
					next_reg_wr    = 1'b1; // RULE17 RULE18
					next_reg_index = wr_data[5:0];
					next_reg_axes  = axes;
					next_reg_wdata = buf_q;
				end
				CMD_CLASS_REG_RD: begin
					next_reg_rd    = 1'b1;
					next_reg_index = wr_data[5:0];
					next_reg_axes  = axes;
					next_rd_load   = axes;
				end
				default: begin
					next_cmd_valid = 1'b1;
				end
			endcase
		end
		if (wr_end && direct) begin
			next_busy_cnt = DIRECT_WAIT_CYCLES; // RULE12 RULE13
			if (dir_first) begin
				next_stage = 32'h0000_0000; // RULE11
			end
			for (int i = 0; i < 4; i++) begin
				if (buf_be[i]) begin
					next_stage[8*i +: 8] = buf_wdata[8*i +: 8];
				end
			end
			if (dir_last) begin
				next_reg_wr          = 1'b1; // RULE11
				next_reg_index       = 6'(wr_addr[7:2] - DIRECT_BIAS);
				next_reg_axes        = mahp_axes_t'(4'h1 << axis);
				next_reg_wdata[axis] = next_stage;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_latch <= 4'h0;
			port_out  <= '0;
			stage     <= 32'h0000_0000;
			busy_cnt  <= CNT_ZERO;
			rd_load   <= '0;
			cmd_valid <= 1'b0;
			cmd_code  <= 8'h00;
			cmd_axes  <= '0;
			reg_wr    <= 1'b0;
			reg_rd    <= 1'b0;
			reg_index <= 6'h00;
			reg_axes  <= '0;
			reg_wdata <= '0;
		end else begin
			sel_latch <= next_sel_latch;
			port_out  <= next_port_out;
			stage     <= next_stage;
			busy_cnt  <= next_busy_cnt;
			rd_load   <= next_rd_load;
			cmd_valid <= next_cmd_valid;
			cmd_code  <= next_cmd_code;
			cmd_axes  <= next_cmd_axes;
			reg_wr    <= next_reg_wr;
			reg_rd    <= next_reg_rd;
			reg_index <= next_reg_index;
			reg_axes  <= next_reg_axes;
			reg_wdata <= next_reg_wdata;
		end
	end

	assign bus.ifb_n = (busy_cnt == CNT_ZERO); // RULE7
	assign bus.wrq_n = bus.cs_n || bus.ifb_n; // RULE8

	// ----------------------------------------------------------------
	// Per-axis transfer buffers
	// ----------------------------------------------------------------
	// Read data is loaded in the same cycle as the read strobe, so the core answers in that cycle.
	for (genvar a = 0; a < 4; a++) begin : g_axis
		mahp_xfer_buffer u_buf (
			.clk       (clk),
			.nrst      (nrst),
			.wr_be     ((wr_end && !direct && ofs[2] && axis == 2'(a)) ? buf_be : 4'h0), // RULE14 RULE15
			.wr_data   (buf_wdata),
			.load      (rd_load[a]),
			.load_data (reg_rdata[a]),
			.data      (buf_q[a])
		);
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [1:0]       rd_axis;
	logic [2:0]       rd_ofs;
	logic [7:0][7:0]  rd_bytes;
	logic [15:0]      next_dev_d;

	always_comb begin
		rd_axis     = bus.addr[9:8];
		rd_ofs      = bus.mode_16 ? {bus.addr[2:1], 1'b0} : bus.addr[2:0];
		rd_bytes[0] = main_state[rd_axis][7:0]; // RULE20
		rd_bytes[1] = main_state[rd_axis][15:8];
		rd_bytes[2] = port_in[rd_axis];
		rd_bytes[3] = sub_state[rd_axis];
		for (int i = 0; i < 4; i++) begin
			rd_bytes[4 + i] = buf_q[rd_axis][8*i +: 8];
		end
		if (bus.full_addr && bus.addr[7:0] >= OFS_DIRECT_BASE) begin
			next_dev_d = 16'h0000; // RULE19
		end else if (bus.mode_16) begin
			next_dev_d = {rd_bytes[rd_ofs | 3'h1], rd_bytes[rd_ofs]};
		end else begin
			next_dev_d = {8'h00, rd_bytes[rd_ofs]};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus.dev_d <= 16'h0000;
		end else begin
			bus.dev_d <= next_dev_d;
		end
	end

	assign bus.dev_d_oe = !bus.cs_n && !bus.rd_n; // RULE20
endmodule
`default_nettype wire

// >>> core/mahp_host.sv
// Host end: runs one bus access per request and keeps the bus pacing.
// Assumes the user issues buffer and command writes in a legal order.
`timescale 1ns/1ps
`default_nettype none
module mahp_host
	import mahp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	mahp_bus_if.host         bus,
	input  wire logic        mode_16,
	input  wire logic        full_addr,
	input  wire logic        req,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic [9:0]  req_addr,
	input  wire logic [15:0] req_wdata,
	output logic             rsp_valid,
	output logic [15:0]      rsp_rdata
);
	mahp_host_state_t state;
	mahp_host_state_t next_state;
	logic [2:0]       cnt;
	logic [2:0]       next_cnt;
	logic             is_wr;
	logic             next_is_wr;
	logic [9:0]       addr_q;
	logic [9:0]       next_addr_q;
	logic [15:0]      wdata_q;
	logic [15:0]      next_wdata_q;
	logic             next_rsp_valid;
	logic [15:0]      next_rsp_rdata;
	logic             cmd_addr;

	assign req_ready     = (state == MAHP_H_IDLE);
	assign bus.mode_16   = mode_16;
	assign bus.full_addr = full_addr;
	assign cmd_addr      = !(full_addr && req_addr[7:0] >= OFS_DIRECT_BASE)
		&& (mode_16 ? req_addr[2:1] == 2'h0 : req_addr[2:0] == OFS_AXIS_SEL);

	always_comb begin
		next_state     = state;
		next_cnt       = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - 3'h1;
		next_is_wr     = is_wr;
		next_addr_q    = addr_q;
		next_wdata_q   = wdata_q;
		next_rsp_valid = 1'b0;
		next_rsp_rdata = rsp_rdata;
		case (state)
			MAHP_H_IDLE: begin
				if (req) begin
					next_state   = MAHP_H_SETUP;
					next_is_wr   = req_write;
					next_addr_q  = req_addr;
					next_wdata_q = req_wdata;
					if (cmd_addr) begin
						// Unused select bits always go out as zero.
						next_wdata_q[15:12] = 4'h0; // RULE2
						if (!mode_16) begin
							next_wdata_q[7:4] = 4'h0;
						end
					end
				end
			end
			MAHP_H_SETUP: begin
				next_state = MAHP_H_STROBE;
				next_cnt   = HOST_STROBE_CYCLES - 3'h1;
			end
			MAHP_H_STROBE: begin
				// Strobe lasts three cycles and stretches while wait is asserted.
				if (cnt == CNT_ZERO && bus.wrq_n) begin // RULE12
					next_state     = MAHP_H_GAP;
					next_cnt       = HOST_GAP_CYCLES;
					next_rsp_valid = 1'b1;
					next_rsp_rdata = is_wr ? 16'h0000 : bus.data;
				end
			end
			MAHP_H_GAP: begin
				// Deselected gap covers buffer, command and direct-write waits.
				if (cnt == CNT_ZERO && bus.ifb_n) begin // RULE9 RULE13 RULE16 RULE17
					next_state = MAHP_H_IDLE;
				end
			end
			default: begin
				next_state = MAHP_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state     <= MAHP_H_IDLE;
			cnt       <= CNT_ZERO;
			is_wr     <= 1'b0;
			addr_q    <= 10'h000;
			wdata_q   <= 16'h0000;
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0000;
		end else begin
			state     <= next_state;
			cnt       <= next_cnt;
			is_wr     <= next_is_wr;
			addr_q    <= next_addr_q;
			wdata_q   <= next_wdata_q;
			rsp_valid <= next_rsp_valid;
			rsp_rdata <= next_rsp_rdata;
		end
	end

	// One word access per request keeps select and code together in word mode.
	assign bus.cs_n      = !(state == MAHP_H_SETUP || state == MAHP_H_STROBE); // RULE6
	assign bus.wr_n      = !(state == MAHP_H_STROBE && is_wr);
	assign bus.rd_n      = !(state == MAHP_H_STROBE && !is_wr);
	assign bus.addr      = addr_q;
	assign bus.host_d    = wdata_q;
	assign bus.host_d_oe = is_wr && !bus.cs_n;
endmodule
`default_nettype wire

// >>> testbench/mahp_bus_monitor.sv
// Concurrent checks on the host port bus between the two ends.
// Assumes the bench instantiates it beside the bus interface, one clock.
`timescale 1ns/1ps
`default_nettype none
module mahp_bus_monitor (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        cs_n,
	input  wire logic        wr_n,
	input  wire logic        rd_n,
	input  wire logic [9:0]  addr,
	input  wire logic [15:0] data,
	input  wire logic        dev_d_oe,
	input  wire logic        wrq_n,
	input  wire logic        ifb_n,
	input  wire logic        mode_16,
	input  wire logic        full_addr
);
	// ----------------------------------------------------------------
	// Bus timing checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_wrq_tracks_busy: assert property (wrq_n == (cs_n | ifb_n))
		else $error("wait request does not follow select and busy");
	a_cmd_busy_len: assert property ($past(!cs_n && !wr_n) && (cs_n || wr_n)
		&& $past(addr[7:1]) == 7'h00 && (mode_16 || !$past(addr[0]))
		|=> !ifb_n [*4] ##1 ifb_n) else $error("command busy period is not four cycles");
	a_buf_busy_len: assert property ($past(!cs_n && !wr_n) && (cs_n || wr_n)
		&& $past(addr[7:3]) == 5'h00 && $past(addr[2])
		|=> !ifb_n [*2] ##1 ifb_n) else $error("buffer busy period is not two cycles");
	a_direct_busy_len: assert property ($past(!cs_n && !wr_n) && (cs_n || wr_n)
		&& full_addr && $past(addr[7:3]) != 5'h00
		|=> !ifb_n [*3] ##1 ifb_n) else $error("direct write busy period is not three cycles");
	a_busy_has_cause: assert property ($fell(ifb_n) |-> $past(cs_n || wr_n)
		&& $past(!cs_n && !wr_n, 2)) else $error("busy began without a finished write");
	a_read_drive_only: assert property (dev_d_oe == (!cs_n && !rd_n))
		else $error("device drives data outside a read");
	a_strobe_min_len: assert property ($fell(wr_n) |-> !wr_n [*3])
		else $error("write strobe shorter than three cycles");
	a_select_gap_len: assert property ($rose(cs_n) |-> cs_n [*4])
		else $error("chip select gap shorter than four cycles");
	a_sel_hi_zero: assert property (mode_16 && !cs_n && !wr_n && addr[7:1] == 7'h00
		|-> data[15:12] == 4'h0) else $error("command word upper bits not zero");

	c_word_cmd: cover property (mode_16 && !cs_n && !wr_n && addr[7:1] == 7'h00);
	c_byte_write: cover property (!mode_16 && !cs_n && !wr_n);
	c_direct_write: cover property (full_addr && !cs_n && !wr_n && addr[7:3] != 5'h00);
	c_bus_read: cover property (!cs_n && !rd_n);
endmodule
`default_nettype wire

// >>> testbench/multi_axis_host_port_tb_top.sv
// Bench joining host end and device end over the bus interface.
// Assumes the host end paces the bus; the bench drives both user sides.
`timescale 1ns/1ps
`default_nettype none
module multi_axis_host_port_tb_top
	import mahp_pkg::*;
;
	typedef struct {logic [2:0] k; logic [7:0] c; mahp_axes_t ax; logic [3:0][31:0] wd;} mahp_ev_t;
	typedef struct {logic rd; logic [15:0] m; logic [15:0] d;} mahp_rs_t;
	logic clk = 1'b0, nrst = 1'b0, mode_16 = 1'b1, full_addr = 1'b0, req = 1'b0, req_write = 1'b0;
	logic [9:0] req_addr = 10'h000;
	logic [15:0] req_wdata = 16'h0000, rsp_rdata;
	logic req_ready, rsp_valid, cmd_valid, reg_wr, reg_rd;
	logic [7:0] cmd_code;
	logic [5:0] reg_index;
	mahp_axes_t cmd_axes, reg_axes;
	logic [3:0][31:0] reg_wdata, reg_rdata, bufm;
	logic [3:0][15:0] main_state;
	logic [3:0][7:0] sub_state, port_in, port_out;
	logic [31:0] rnd = 32'h72ce;
	int error_cnt = 0, tests_run = 0;
	mahp_ev_t eq[$];
	mahp_rs_t rq[$];

	always #5 clk = ~clk;
	mahp_bus_if mahp_bus_if_i ();
	mahp_device mahp_device_i (.clk(clk), .nrst(nrst), .bus(mahp_bus_if_i), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_axes(cmd_axes), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_index(reg_index), .reg_axes(reg_axes), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.main_state(main_state), .sub_state(sub_state), .port_in(port_in), .port_out(port_out));
	mahp_host mahp_host_i (.clk(clk), .nrst(nrst), .bus(mahp_bus_if_i), .mode_16(mode_16),
		.full_addr(full_addr), .req(req), .req_ready(req_ready), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	mahp_bus_monitor mahp_bus_monitor_i (.clk(clk), .nrst(nrst), .cs_n(mahp_bus_if_i.cs_n),
		.wr_n(mahp_bus_if_i.wr_n), .rd_n(mahp_bus_if_i.rd_n), .addr(mahp_bus_if_i.addr),
		.data(mahp_bus_if_i.data), .dev_d_oe(mahp_bus_if_i.dev_d_oe), .wrq_n(mahp_bus_if_i.wrq_n),
		.ifb_n(mahp_bus_if_i.ifb_n), .mode_16(mahp_bus_if_i.mode_16),
		.full_addr(mahp_bus_if_i.full_addr));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrdy();
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 200) begin
			chk("host ready timeout", 32'h1, 32'h0);
			print_verdict();
		end
	endtask
	// Issue one host access; a read carries the expected data and its mask.
	task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d, input logic [15:0] m);
		wrdy();
		rq.push_back('{!w, m, d});
		req = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(posedge clk);
		#1;
		req = 1'b0;
	endtask
	task automatic ev(input logic [2:0] k, input logic [7:0] c, input mahp_axes_t ax);
		eq.push_back('{k, c, ax, bufm});
	endtask
	// Word mode command write at the command word of axis a.
	task automatic wcmd(input logic [1:0] a, input mahp_axes_t s, input logic [7:0] c,
		input logic [2:0] k);
		ev(k, c, (s == 4'h0) ? mahp_axes_t'(4'h1 << a) : s);
		acc(1'b1, {a, 8'h00}, {4'h0, s, c}, 16'h0000);
	endtask

	// ----------------------------------------------------------------
	// Result watcher
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		mahp_ev_t e;
		mahp_rs_t r;
		if (cmd_valid === 1'b1 || reg_wr === 1'b1 || reg_rd === 1'b1) begin
			if (eq.size() > 0) begin
				e = eq.pop_front();
			end else begin
				e = '{3'h0, 8'h00, 4'h0, '0};
			end
			chk("event kind", {reg_rd, reg_wr, cmd_valid}, e.k);
			if (e.k == 3'h1) begin
				chk("cmd_code", cmd_code, e.c);
				chk("cmd_axes", cmd_axes, e.ax);
			end else begin
				chk("reg_index", reg_index, e.c[5:0]);
				chk("reg_axes", reg_axes, e.ax);
			end
			for (int i = 0; i < 4; i++)
				if (e.k == 3'h2 && e.ax[i])
					chk("reg_wdata", reg_wdata[i], e.wd[i]);
		end
		if (rsp_valid === 1'b1) begin
			if (rq.size() > 0) begin
				r = rq.pop_front();
			end else begin
				r = '{1'b1, 16'hFFFF, 16'hDEAD};
			end
			if (r.rd)
				chk("read data", rsp_rdata & r.m, r.d & r.m);
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [1:0] a;
		logic [5:0] ix;
		logic [7:0] v;
		bufm = '0;
		reg_rdata = {lfsr(32'h1), lfsr(32'h2), lfsr(32'h3), lfsr(32'h4)};
		main_state = {16'hA55A, 16'h1234, 16'hC3E1, 16'h0F0F};
		sub_state = 32'h1357_9BDF;
		port_in = 32'h2468_ACE0;
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			wcmd(2'(i % 4), (i < 4) ? 4'h0 : ((i == 9) ? 4'hF : rnd[3:0]), {1'b0, rnd[14:8]}, 3'h1);
		end
		$display("test command words done");
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			bufm[i] = rnd;
			acc(1'b1, {i[1:0], 8'h06}, rnd[31:16], 16'h0000);
			acc(1'b1, {i[1:0], 8'h04}, rnd[15:0], 16'h0000);
		end
		wcmd(2'd2, 4'hF, 8'h85, 3'h2);
		bufm[1][15:0] = 16'h5AA5;
		acc(1'b1, {2'd1, 8'h04}, 16'h5AA5, 16'h0000);
		wcmd(2'd0, 4'h2, 8'h9E, 3'h2);
		$display("test indirect write done");
		wcmd(2'd3, 4'h5, 8'hC7, 3'h4);
		bufm[0] = reg_rdata[0];
		bufm[2] = reg_rdata[2];
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, {i[1:0], 8'h04}, bufm[i][15:0], 16'hFFFF);
			acc(1'b0, {i[1:0], 8'h06}, bufm[i][31:16], 16'hFFFF);
			acc(1'b0, {i[1:0], 8'h00}, main_state[i], 16'hFFFF);
			acc(1'b0, {i[1:0], 8'h02}, {sub_state[i], port_in[i]}, 16'hFFFF);
			v = rnd[7:0] ^ i[7:0];
			acc(1'b1, {i[1:0], 8'h02}, {8'h00, v}, 16'h0000);
			wrdy();
			chk("port_out", port_out[i], v);
		end
		$display("test read and status done");
		mode_16 = 1'b0;
		acc(1'b1, {2'd0, 8'h01}, 16'h000A, 16'h0000);
		ev(3'h1, 8'h21, 4'hA);
		acc(1'b1, {2'd0, 8'h00}, 16'h0021, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			bufm[3][8 * (3 - i) +: 8] = rnd[7:0];
			acc(1'b1, {2'd3, 6'h01, 2'(3 - i)}, {8'h00, rnd[7:0]}, 16'h0000);
		end
		acc(1'b1, {2'd3, 8'h01}, 16'h0000, 16'h0000);
		ev(3'h2, 8'h83, 4'h8);
		acc(1'b1, {2'd3, 8'h00}, 16'h0083, 16'h0000);
		acc(1'b0, {2'd3, 8'h00}, main_state[3], 16'h00FF);
		acc(1'b0, {2'd3, 8'h01}, {8'h00, main_state[3][15:8]}, 16'h00FF);
		acc(1'b0, {2'd3, 8'h03}, {8'h00, sub_state[3]}, 16'h00FF);
		$display("test byte mode done");
		for (int i = 0; i < 4; i++) begin
			// Mode pins change only while the host is idle, never inside an access.
			wrdy();
			mode_16 = i[0];
			full_addr = 1'b1;
			rnd = lfsr(rnd);
			a = rnd[9:8];
			ix = 6'h02 + {1'b0, rnd[20:16]};
			bufm[a] = lfsr(rnd);
			ev(3'h2, {2'b00, ix - 6'h02}, mahp_axes_t'(4'h1 << a));
			if (mode_16) begin
				acc(1'b1, {a, ix, 2'b00}, bufm[a][15:0], 16'h0000);
				acc(1'b1, {a, ix, 2'b10}, bufm[a][31:16], 16'h0000);
			end else begin
				for (int k = 0; k < 4; k++)
					acc(1'b1, {a, ix, 2'(k)}, {8'h00, bufm[a][8 * k +: 8]}, 16'h0000);
			end
		end
		$display("test direct write done");
		for (int n = 0; n < 300 && (eq.size() > 0 || rq.size() > 0); n++)
			@(posedge clk);
		repeat (10) @(posedge clk);
		chk("pending results", eq.size() + rq.size(), 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
